// ---- verilog/status_bank_defines.svh ----
// offsets, field positions, reset values and id defaults of the status bank
`ifndef STATUS_BANK_DEFINES_SVH
`define STATUS_BANK_DEFINES_SVH
`define ADDR_WAKE_PIN_LEVEL_STATUS 7'h48
`define ADDR_SWITCH_OVERLOAD_STATUS 7'h54
`define ADDR_SWITCH_OPEN_LOAD_STATUS 7'h55
`define ADDR_CHIP_IDENTITY 7'h7e
`define LVL_WAKE_LSB 0
`define LVL_GP_LSB 4
`define LVL_CFG_PULLUP_BIT 6
`define LVL_DEV_MODE_BIT 7
`define ID_LINE_LSB 4
`define ID_VARIANT_LSB 0
`define SWITCH_FLAGS_RESET 4'h0
`define GP_LEVEL_RESET 2'h0
`define PRODUCT_LINE_DEFAULT 4'h5
`define VARIANT_DEFAULT 4'h9
`endif

// ---- verilog/status_bank_pkg.sv ----
// types shared by the status bank files
package status_bank_pkg;
  // reset kinds that reach the bank
  typedef enum logic [1:0] {
    RST_NONE,
    RST_POWER_ON,
    RST_SOFT,
    RST_RESTART
  } reset_kind_t;
  // per-pin wake sense configuration
  typedef enum logic [1:0] {
    SENSE_STATIC,
    SENSE_CYCLIC,
    SENSE_CYCLIC_WAKE
  } sense_mode_t;
  // use of a general-purpose pin
  typedef enum logic [2:0] {
    GP_OFF,
    GP_WAKE,
    GP_LOW_SIDE,
    GP_HIGH_SIDE,
    GP_GENERAL
  } gp_use_t;
  // operating mode of the chip
  typedef enum logic [1:0] {
    OPM_NORMAL,
    OPM_STOP,
    OPM_SLEEP,
    OPM_RESTART
  } op_mode_t;
  // register read request and answer
  typedef struct packed {
    logic rd;
    logic clr;
    logic [6:0] addr;
  } reg_req_t;
  typedef struct packed {
    logic hit;
    logic [7:0] data;
  } reg_rsp_t;
endpackage : status_bank_pkg

// ---- verilog/sticky_flags.sv ----
// sticky fault flags with read-clear, set winning over clear
`include "status_bank_defines.svh"
module sticky_flags #(
  parameter int WIDTH = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire status_bank_pkg::reset_kind_t i_reset_kind,
  input wire logic [WIDTH-1:0] i_detect,
  input wire logic i_clear,
  output logic [WIDTH-1:0] o_flags
);
  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  initial begin
    if (WIDTH < 1 || WIDTH > 8) begin
      $error("sticky_flags width must be 1 to 8");
    end
  end

  // restart keeps flags; power-on and soft reset wipe them
  always_comb begin
    flags_nxt = flags_r;
    if (i_reset_kind == status_bank_pkg::RST_POWER_ON ||
        i_reset_kind == status_bank_pkg::RST_SOFT) begin
      flags_nxt = '0;
    end else begin
      if (i_clear) begin
        flags_nxt = '0;
      end
      flags_nxt = flags_nxt | i_detect; // set wins, refault re-sets
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign o_flags = flags_r;

  a_flag_sticks: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_reset_kind == status_bank_pkg::RST_NONE && !i_clear) |=>
      ((flags_r & $past(flags_r)) == $past(flags_r)))
    else $error("flag dropped without clear");
  a_flag_set_wins: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_reset_kind != status_bank_pkg::RST_POWER_ON &&
     i_reset_kind != status_bank_pkg::RST_SOFT) |=>
      ((flags_r & $past(i_detect)) == $past(i_detect)))
    else $error("detection lost");
endmodule : sticky_flags

// ---- verilog/wake_level_and_switch_status.sv ----
// status register bank: pin levels, switch faults and chip identity
`include "status_bank_defines.svh"
module wake_level_and_switch_status #(
  parameter int NUM_WAKE = 3,
  parameter int NUM_SWITCH = 4,
  parameter logic [3:0] PRODUCT_LINE = `PRODUCT_LINE_DEFAULT, // arbitrary value
  parameter logic [3:0] VARIANT = `VARIANT_DEFAULT // arbitrary value
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire status_bank_pkg::reset_kind_t i_reset_kind,
  input wire status_bank_pkg::op_mode_t i_op_mode,
  input wire logic [NUM_WAKE-1:0] i_wake_level,
  input wire status_bank_pkg::sense_mode_t [NUM_WAKE-1:0] i_wake_sense,
  input wire logic [NUM_WAKE-1:0] i_wake_sample,
  input wire logic [1:0] i_gp_level,
  input wire status_bank_pkg::gp_use_t [1:0] i_gp_use,
  input wire logic i_fail_out3_test_pin,
  input wire logic i_config_pullup_detect,
  input wire logic [NUM_SWITCH-1:0] i_overload_detect,
  input wire logic [NUM_SWITCH-1:0] i_open_load_detect,
  input wire status_bank_pkg::reg_req_t i_req,
  output status_bank_pkg::reg_rsp_t o_rsp
);
  logic [NUM_WAKE-1:0] wake_r;
  logic [NUM_WAKE-1:0] wake_nxt;
  logic [1:0] gp_r;
  logic [1:0] gp_nxt;
  logic dev_mode_pin_level_r;
  logic config_pullup_detect_r;
  logic [NUM_SWITCH-1:0] overload_flags;
  logic [NUM_SWITCH-1:0] open_load_flags;
  logic clr_overload;
  logic clr_open_load;
  status_bank_pkg::reg_rsp_t rsp_r;
  status_bank_pkg::reg_rsp_t rsp_nxt;
  logic [7:0] lvl_word;

  initial begin
    if (NUM_WAKE != 3 || NUM_SWITCH < 1 || NUM_SWITCH > 4) begin
      $error("unsupported wake or switch count");
    end
  end

  // wake levels: live when static, held sample when cyclic
  always_comb begin
    wake_nxt = wake_r;
    for (int i = 0; i < NUM_WAKE; i++) begin
      if (i_wake_sense[i] == status_bank_pkg::SENSE_STATIC) begin
        wake_nxt[i] = i_wake_level[i];
      end else if (i_wake_sample[i]) begin
        wake_nxt[i] = i_wake_level[i];
      end
    end
  end

  // gp levels are live in general use or, as wake or switch pins, in normal or stop mode; never sampled cyclically
  always_comb begin
    gp_nxt = gp_r;
    for (int i = 0; i < 2; i++) begin
      if (i_gp_use[i] == status_bank_pkg::GP_GENERAL) begin
        gp_nxt[i] = i_gp_level[i];
      end else if ((i_op_mode == status_bank_pkg::OPM_NORMAL ||
                    i_op_mode == status_bank_pkg::OPM_STOP) &&
                   (i_gp_use[i] == status_bank_pkg::GP_WAKE ||
                    i_gp_use[i] == status_bank_pkg::GP_LOW_SIDE ||
                    i_gp_use[i] == status_bank_pkg::GP_HIGH_SIDE)) begin
        gp_nxt[i] = i_gp_level[i];
      end
    end
    if (i_reset_kind == status_bank_pkg::RST_POWER_ON ||
        i_reset_kind == status_bank_pkg::RST_SOFT) begin
      gp_nxt = `GP_LEVEL_RESET; // restart leaves levels live
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wake_r <= '0;
      gp_r <= `GP_LEVEL_RESET;
      dev_mode_pin_level_r <= 1'b0;
      config_pullup_detect_r <= 1'b0;
    end else begin
      wake_r <= wake_nxt;
      gp_r <= gp_nxt;
      dev_mode_pin_level_r <= i_fail_out3_test_pin;
      config_pullup_detect_r <= i_config_pullup_detect;
    end
  end

  // clear access: a read with clear on the flag registers
  assign clr_overload = i_req.rd && i_req.clr &&
    i_req.addr == `ADDR_SWITCH_OVERLOAD_STATUS;
  assign clr_open_load = i_req.rd && i_req.clr &&
    i_req.addr == `ADDR_SWITCH_OPEN_LOAD_STATUS;

  sticky_flags #(.WIDTH(NUM_SWITCH)) u_overload (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_reset_kind(i_reset_kind),
    .i_detect(i_overload_detect),
    .i_clear(clr_overload),
    .o_flags(overload_flags)
  );

  sticky_flags #(.WIDTH(NUM_SWITCH)) u_open_load (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_reset_kind(i_reset_kind),
    .i_detect(i_open_load_detect),
    .i_clear(clr_open_load),
    .o_flags(open_load_flags)
  );

  // level word; bit 3 is reserved and tied low
  always_comb begin
    lvl_word = 8'h00;
    lvl_word[`LVL_WAKE_LSB +: 3] = wake_r;
    lvl_word[`LVL_GP_LSB +: 2] = gp_r;
    lvl_word[`LVL_CFG_PULLUP_BIT] = config_pullup_detect_r;
    lvl_word[`LVL_DEV_MODE_BIT] = dev_mode_pin_level_r;
  end

  // read mux; the answer returns the value before any clear takes effect
  always_comb begin
    rsp_nxt = '0;
    if (i_req.rd) begin
      rsp_nxt.hit = 1'b1;
      case (i_req.addr)
        `ADDR_WAKE_PIN_LEVEL_STATUS: rsp_nxt.data = lvl_word;
        `ADDR_SWITCH_OVERLOAD_STATUS: rsp_nxt.data = 8'(overload_flags);
        `ADDR_SWITCH_OPEN_LOAD_STATUS: rsp_nxt.data = 8'(open_load_flags);
        `ADDR_CHIP_IDENTITY: begin
          rsp_nxt.data[`ID_LINE_LSB +: 4] = PRODUCT_LINE;
          rsp_nxt.data[`ID_VARIANT_LSB +: 4] = VARIANT; // constant for all resets
        end
        default: begin
          rsp_nxt.hit = 1'b0;
          rsp_nxt.data = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  assign o_rsp = rsp_r;

  // read path: the answer stands one cycle after the request, then drops to zero
  a_lvl_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == `ADDR_WAKE_PIN_LEVEL_STATUS) |=>
      (o_rsp.hit && o_rsp.data[3] == 1'b0))
    else $error("reserved level bit nonzero");

  a_lvl_word_read: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == `ADDR_WAKE_PIN_LEVEL_STATUS) |=>
      (o_rsp.data == $past(lvl_word)))
    else $error("level word not returned");

  a_overload_read: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == `ADDR_SWITCH_OVERLOAD_STATUS) |=>
      (o_rsp.hit && o_rsp.data == 8'($past(overload_flags))))
    else $error("overload register read wrong");

  a_open_load_read: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == `ADDR_SWITCH_OPEN_LOAD_STATUS) |=>
      (o_rsp.hit && o_rsp.data == 8'($past(open_load_flags))))
    else $error("open load register read wrong");

  // unmapped addresses answer with a miss so the host can tell them apart
  a_unmapped_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_req.rd && !(i_req.addr inside {`ADDR_WAKE_PIN_LEVEL_STATUS,
      `ADDR_SWITCH_OVERLOAD_STATUS, `ADDR_SWITCH_OPEN_LOAD_STATUS,
      `ADDR_CHIP_IDENTITY})) |=> (o_rsp == '0))
    else $error("unmapped address answered");

  a_idle_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!i_req.rd) |=> (o_rsp == '0))
    else $error("answer without request");

  // wake inputs: live in static sense, sampled in cyclic sense
  a_wake_live: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_wake_sense[0] == status_bank_pkg::SENSE_STATIC) |=>
      (wake_r[0] == $past(i_wake_level[0])))
    else $error("wake level not followed");

  a_wake_held: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_wake_sense[1] != status_bank_pkg::SENSE_STATIC && !i_wake_sample[1]) |=>
      $stable(wake_r[1]))
    else $error("cyclic wake level changed without sample");

  a_wake_sampled: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_wake_sense[2] != status_bank_pkg::SENSE_STATIC && i_wake_sample[2]) |=>
      (wake_r[2] == $past(i_wake_level[2])))
    else $error("cyclic sample not taken");

  // gp pins: live in general use, refreshed in normal or stop mode as wake or switch pins
  a_gp_general: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_gp_use[0] == status_bank_pkg::GP_GENERAL && i_reset_kind == status_bank_pkg::RST_NONE)
      |=> (gp_r[0] == $past(i_gp_level[0])))
    else $error("gp level not shown");

  a_gp_never_cyclic: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_gp_use[1] == status_bank_pkg::GP_GENERAL && i_reset_kind == status_bank_pkg::RST_NONE)
      |=> (gp_r[1] == $past(i_gp_level[1])))
    else $error("gp level lags the pin");

  a_gp_refresh: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ((i_op_mode == status_bank_pkg::OPM_NORMAL || i_op_mode == status_bank_pkg::OPM_STOP) &&
     i_gp_use[1] inside {status_bank_pkg::GP_WAKE, status_bank_pkg::GP_LOW_SIDE,
                         status_bank_pkg::GP_HIGH_SIDE} &&
     i_reset_kind == status_bank_pkg::RST_NONE) |=> (gp_r[1] == $past(i_gp_level[1])))
    else $error("gp level not refreshed");

  a_gp_sleep_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_op_mode == status_bank_pkg::OPM_SLEEP && i_gp_use[0] != status_bank_pkg::GP_GENERAL &&
     i_reset_kind == status_bank_pkg::RST_NONE) |=> $stable(gp_r[0]))
    else $error("gp level moved while held");

  a_gp_reset_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_reset_kind == status_bank_pkg::RST_SOFT) |=> (gp_r == 2'h0))
    else $error("gp level not cleared");

  a_gp_poweron_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_reset_kind == status_bank_pkg::RST_POWER_ON) |=> (gp_r == 2'h0))
    else $error("gp level not cleared at power-on");

  a_gp_restart_live: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_reset_kind == status_bank_pkg::RST_RESTART &&
     i_gp_use[0] == status_bank_pkg::GP_GENERAL) |=> (gp_r[0] == $past(i_gp_level[0])))
    else $error("gp level forced on restart");

  // mode and configuration sense pins pass through one flop
  a_dev_mode_bit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == `ADDR_WAKE_PIN_LEVEL_STATUS) ##1 1'b1 |->
      (o_rsp.data[7] == $past(dev_mode_pin_level_r)))
    else $error("dev mode bit wrong");

  a_dev_mode_sense: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> (dev_mode_pin_level_r == $past(i_fail_out3_test_pin)))
    else $error("dev mode pin not sensed");

  a_cfg_pullup_sense: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> (config_pullup_detect_r == $past(i_config_pullup_detect)))
    else $error("pull-up detection not sensed");

  a_id_constant: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == `ADDR_CHIP_IDENTITY) |=>
      (o_rsp.data == {PRODUCT_LINE, VARIANT}))
    else $error("identity wrong");

  // switch flags: wiped by power-on and soft reset, kept by restart
  a_flags_poweron: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_reset_kind == status_bank_pkg::RST_POWER_ON) |=>
      (overload_flags == '0 && open_load_flags == '0))
    else $error("flags survive power-on");

  a_flags_soft: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_reset_kind == status_bank_pkg::RST_SOFT) |=>
      (overload_flags == '0 && open_load_flags == '0))
    else $error("flags survive soft reset");

  a_flags_restart: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_reset_kind == status_bank_pkg::RST_RESTART && !clr_overload) |=>
      ((overload_flags & $past(overload_flags)) == $past(overload_flags)))
    else $error("flags lost on restart");

  // a clear leaves only what is detected in the same cycle
  a_clear_overload: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (clr_overload && i_reset_kind inside {status_bank_pkg::RST_NONE,
                                           status_bank_pkg::RST_RESTART}) |=>
      (overload_flags == $past(i_overload_detect)))
    else $error("overload clear wrong");

  a_clear_open_load: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (clr_open_load && i_reset_kind inside {status_bank_pkg::RST_NONE,
                                            status_bank_pkg::RST_RESTART}) |=>
      (open_load_flags == $past(i_open_load_detect)))
    else $error("open load clear wrong");

  c_overload_read: cover property (@(posedge i_sys_clk) overload_flags != '0 ##1 clr_overload);
  c_open_load_set: cover property (@(posedge i_sys_clk) open_load_flags != '0);
  c_cyclic_sample: cover property (@(posedge i_sys_clk)
    i_wake_sense[0] == status_bank_pkg::SENSE_CYCLIC && i_wake_sample[0]);
  c_restart: cover property (@(posedge i_sys_clk) i_reset_kind == status_bank_pkg::RST_RESTART);
  c_sleep_hold: cover property (@(posedge i_sys_clk)
    i_op_mode == status_bank_pkg::OPM_SLEEP && i_gp_use[0] == status_bank_pkg::GP_WAKE);
endmodule : wake_level_and_switch_status

// ---- bench/status_host.sv ----
// host model that reads the status bank one register at a time
module status_host (
  input wire logic i_sys_clk,
  output status_bank_pkg::reg_req_t o_req,
  input wire status_bank_pkg::reg_rsp_t i_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_req = '0;
  // one-cycle request, answer taken one edge later; the answer is handed back to the caller unchecked
  task automatic read_reg(input logic [6:0] addr, input logic clr,
                          output status_bank_pkg::reg_rsp_t rsp);
    @(posedge i_sys_clk);
    o_req <= {1'b1, clr, addr};
    @(posedge i_sys_clk);
    o_req <= '0;
    #1;
    rsp = i_rsp;
  endtask : read_reg
endmodule : status_host

// ---- bench/wake_level_and_switch_status_bench.sv ----
// self-checking bench for the status register bank
module wake_level_and_switch_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] LINE = 4'ha; // arbitrary value
  localparam logic [3:0] VAR = 4'h6; // arbitrary value
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  status_bank_pkg::reset_kind_t kind = status_bank_pkg::RST_NONE;
  status_bank_pkg::op_mode_t mode = status_bank_pkg::OPM_NORMAL;
  status_bank_pkg::sense_mode_t [2:0] sense = {3{status_bank_pkg::SENSE_STATIC}};
  status_bank_pkg::gp_use_t [1:0] gp_use = {2{status_bank_pkg::GP_GENERAL}};
  logic [2:0] wake = 3'h0;
  logic [2:0] sample = 3'h0;
  logic [1:0] gp = 2'h0;
  logic dev = 1'b0;
  logic cfg = 1'b0;
  logic [3:0] ovl = 4'h0;
  logic [3:0] opn = 4'h0;
  logic [3:0] r1;
  logic [3:0] r2;
  status_bank_pkg::reset_kind_t k;
  status_bank_pkg::reg_req_t req;
  status_bank_pkg::reg_rsp_t rsp_w;
  status_bank_pkg::reg_rsp_t rsp;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;

  always #12.5 i_sys_clk = ~i_sys_clk;

  wake_level_and_switch_status #(.PRODUCT_LINE(LINE), .VARIANT(VAR)) u_wake_level_and_switch_status (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reset_kind(kind), .i_op_mode(mode),
    .i_wake_level(wake), .i_wake_sense(sense), .i_wake_sample(sample), .i_gp_level(gp),
    .i_gp_use(gp_use), .i_fail_out3_test_pin(dev), .i_config_pullup_detect(cfg),
    .i_overload_detect(ovl), .i_open_load_detect(opn), .i_req(req), .o_rsp(rsp_w));
  status_host u_status_host (.i_sys_clk(i_sys_clk), .o_req(req), .i_rsp(rsp_w));

  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic expect_reg(input string what, input logic [6:0] a, input logic c,
                            input logic [8:0] exp);
    u_status_host.read_reg(a, c, rsp);
    check(what, rsp, exp);
  endtask : expect_reg

  // one-cycle fault pulses on the switch detectors
  task automatic pulse(input logic [3:0] a, input logic [3:0] b);
    @(posedge i_sys_clk);
    ovl <= a;
    opn <= b;
    @(posedge i_sys_clk);
    ovl <= 4'h0;
    opn <= 4'h0;
  endtask : pulse

  // level register image built from what the bench drives
  function automatic logic [8:0] lvl_exp();
    return {1'b1, dev, cfg, gp, 1'b0, wake};
  endfunction : lvl_exp

  // hang guard, far above the roughly 160 cycles the run needs
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(65));
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    expect_reg("identity", 7'h7e, 1'b0, {1'b1, LINE, VAR});
    expect_reg("unmapped", 7'h49, 1'b0, 9'h000);
    // random pin levels, gp uses and normal or stop mode
    for (int i = 0; i < 24; i++) begin
      @(posedge i_sys_clk);
      wake <= 3'($urandom);
      gp <= 2'($urandom);
      dev <= 1'($urandom);
      cfg <= 1'($urandom);
      gp_use[0] <= status_bank_pkg::gp_use_t'(1 + $urandom % 4);
      gp_use[1] <= status_bank_pkg::gp_use_t'(1 + $urandom % 4);
      mode <= status_bank_pkg::op_mode_t'($urandom % 2);
      #1;
      expect_reg("level", 7'h48, 1'b0, lvl_exp());
    end
    // sticky flags, read-clear, and a fault still present at the clear
    r1 = 4'($urandom);
    r2 = 4'($urandom) | 4'h1;
    pulse(r1, r2);
    expect_reg("overload", 7'h54, 1'b1, {5'h10, r1});
    expect_reg("open load", 7'h55, 1'b1, {5'h10, r2});
    expect_reg("overload cleared", 7'h54, 1'b0, 9'h100);
    @(posedge i_sys_clk);
    ovl <= 4'hf;
    expect_reg("overload held", 7'h54, 1'b1, 9'h10f);
    expect_reg("overload again", 7'h54, 1'b1, 9'h10f);
    ovl <= 4'h0;
    expect_reg("overload last", 7'h54, 1'b1, 9'h10f);
    expect_reg("overload gone", 7'h54, 1'b0, 9'h100);
    // each reset kind: restart keeps flags and levels, the others clear
    for (int i = 1; i < 4; i++) begin
      k = status_bank_pkg::reset_kind_t'(i);
      @(posedge i_sys_clk);
      gp_use <= {2{status_bank_pkg::GP_GENERAL}};
      gp <= 2'h3;
      repeat (2) @(posedge i_sys_clk);
      gp_use <= {2{status_bank_pkg::GP_OFF}};
      pulse(4'h5, 4'ha);
      @(posedge i_sys_clk);
      kind <= k;
      @(posedge i_sys_clk);
      kind <= status_bank_pkg::RST_NONE;
      expect_reg("overload kept", 7'h54, 1'b0,
                 (k == status_bank_pkg::RST_RESTART) ? 9'h105 : 9'h100);
      expect_reg("open load kept", 7'h55, 1'b0,
                 (k == status_bank_pkg::RST_RESTART) ? 9'h10a : 9'h100);
      u_status_host.read_reg(7'h48, 1'b0, rsp);
      check("gp level", {7'h0, rsp.data[5:4]},
            (k == status_bank_pkg::RST_RESTART) ? 9'h003 : 9'h000);
      expect_reg("identity kept", 7'h7e, 1'b0, {1'b1, LINE, VAR});
    end
    // cyclic sense holds the last sample until the next sampling pulse
    @(posedge i_sys_clk);
    sense <= {status_bank_pkg::SENSE_CYCLIC, status_bank_pkg::SENSE_CYCLIC,
              status_bank_pkg::SENSE_CYCLIC_WAKE};
    wake <= 3'h0;
    sample <= 3'h7;
    @(posedge i_sys_clk);
    sample <= 3'h0;
    wake <= 3'h7;
    repeat (2) @(posedge i_sys_clk);
    u_status_host.read_reg(7'h48, 1'b0, rsp);
    check("wake held", {6'h0, rsp.data[2:0]}, 9'h000);
    @(posedge i_sys_clk);
    sample <= 3'h2;
    @(posedge i_sys_clk);
    sample <= 3'h0;
    u_status_host.read_reg(7'h48, 1'b0, rsp);
    check("wake sampled", {6'h0, rsp.data[2:0]}, 9'h002);
    // sleep holds gp levels of wake pins; stop refreshes them
    @(posedge i_sys_clk);
    gp_use <= {2{status_bank_pkg::GP_WAKE}};
    mode <= status_bank_pkg::OPM_SLEEP;
    gp <= 2'h0;
    repeat (2) @(posedge i_sys_clk);
    u_status_host.read_reg(7'h48, 1'b0, rsp);
    check("gp held", {7'h0, rsp.data[5:4]}, 9'h003);
    mode <= status_bank_pkg::OPM_STOP;
    u_status_host.read_reg(7'h48, 1'b0, rsp);
    check("gp refreshed", {7'h0, rsp.data[5:4]}, 9'h000);
    print_verdict();
  end
endmodule : wake_level_and_switch_status_bench
